// File: design/trm_ctrl.sv
// termination control for the data, mask and strobe pins of a ddr dram
// assumes an AXI4-Lite master for configuration and same-clock command strobes
`timescale 1ns/1ps
module trm_ctrl (
  input  wire logic                       MCLK,
  input  wire logic                       RESET,
  input  wire logic [trm_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                       AWVALID,
  output logic                            AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic [3:0]                 WSTRB,
  input  wire logic                       WVALID,
  output logic                            WREADY,
  output logic [1:0]                      BRESP,
  output logic                            BVALID,
  input  wire logic                       BREADY,
  input  wire logic [trm_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                       ARVALID,
  output logic                            ARREADY,
  output logic [31:0]                     RDATA,
  output logic [1:0]                      RRESP,
  output logic                            RVALID,
  input  wire logic                       RREADY,
  input  wire logic                       TERM_EN_PIN,
  input  wire logic                       READ_CMD,
  input  wire logic                       WRITE_CMD,
  input  wire logic                       BURST_CHOP,
  input  wire logic                       SELF_REFRESH,
  input  wire logic                       DLL_LOCKED,
  input  wire logic                       X8_DEVICE,
  output trm_pkg::trm_state_t             DQ_TERM_STATE,
  output logic [2:0]                      DQ_TERM_CODE,
  output logic [2:0]                      TDQS_TERM_CODE,
  output logic                            TERM_RX_ON
);
  import trm_pkg::*;

  function automatic logic [TAP_W-1:0] lat_sub(input logic [FLD_W-1:0] a,
                                               input logic [FLD_W-1:0] b,
                                               input logic [FLD_W-1:0] c,
                                               input logic             pre2);
    logic [6:0] s;
    logic [6:0] d;
    s = 7'(a) + 7'(b) + 7'(c);
    d = pre2 ? PRE2_SUB : PRE1_SUB;
    s = (s > d) ? s - d : 7'h00;
    lat_sub = (s > LAT_MAX) ? TAP_W'(LAT_MAX) : TAP_W'(s);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  // register file and bus state
  logic [11:0]       ctrl;
  logic [19:0]       lat;
  logic              aw_held;
  logic              w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0]       w_data;
  logic [3:0]        w_strb;
  logic [11:0]       next_ctrl;
  logic [19:0]       next_lat;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ADDR_W-1:0] next_aw_addr;
  logic [31:0]       next_w_data;
  logic [3:0]        next_w_strb;
  logic [1:0]        next_bresp;
  logic              next_bvalid;
  logic [31:0]       next_rdata;
  logic [1:0]        next_rresp;
  logic              next_rvalid;
  logic              hold_clr;
  logic [ADDR_W-1:0] wa;
  logic [31:0]       wd;
  logic [3:0]        ws;
  logic              do_wr;

  // pin synchroniser, hold check
  logic       s1;
  logic       s2;
  logic       s3;
  logic       filt;
  logic       pin_prev;
  logic [2:0] hold_cnt;
  logic       hold_err;
  logic       next_filt;
  logic       next_pin_prev;
  logic [2:0] next_hold_cnt;
  logic       next_hold_err;
  logic [2:0] hold_min;
  logic       hold_viol;

  // termination datapath
  logic [2:0]       rtt_nom;
  logic [2:0]       rtt_park;
  logic [1:0]       rtt_wr;
  logic             pre2;
  logic             crc;
  logic             pin_eff;
  logic             sync_mode;
  logic [TAP_W-1:0] dir_lat;
  logic [TAP_W-1:0] rd_off;
  logic [LEN_W-1:0] half_bl;
  logic [LEN_W-1:0] rd_len;
  logic [LEN_W-1:0] wr_len;
  logic             nom_dly;
  logic             nom_req;
  logic             rd_act;
  logic             wr_act;
  trm_state_t       next_state;
  logic [2:0]       next_code;
  logic [2:0]       next_tdqs;
  logic [31:0]      stat;

  assign rtt_nom  = ctrl[NOM_LSB +: 3];
  assign rtt_park = ctrl[PARK_LSB +: 3];
  assign rtt_wr   = ctrl[WRT_LSB +: 2];
  assign pre2     = ctrl[PRE2_BIT];
  assign crc      = ctrl[CRC_BIT];

  assign AWREADY = !aw_held && !BVALID;
  assign WREADY  = !w_held && !BVALID;
  assign ARREADY = !RVALID;

  // nominal disabled: receiver off and pin reads as low
  assign TERM_RX_ON = (rtt_nom != 3'h0) && !SELF_REFRESH;
  assign pin_eff    = filt && TERM_RX_ON;
  assign sync_mode  = DLL_LOCKED && !SELF_REFRESH;

  assign dir_lat = lat_sub(lat[CASW_LSB +: FLD_W], lat[ADDL_LSB +: FLD_W],
                           lat[PARL_LSB +: FLD_W], pre2);
  assign rd_off  = lat_sub(lat[CASR_LSB +: FLD_W], lat[ADDL_LSB +: FLD_W],
                           lat[PARL_LSB +: FLD_W], pre2);
  assign half_bl = BURST_CHOP ? HALF_CHOP : HALF_FULL;
  // window covers preamble and burst, plus crc on reads, so parking returns only once driving stops
  assign rd_len  = half_bl + LEN_W'(pre2 ? PRE2_SUB : PRE1_SUB) + LEN_W'(crc);
  assign wr_len  = half_bl + LEN_W'(pre2 ? PRE2_SUB : PRE1_SUB);

  trm_delay u_delay (
    .clk  (MCLK),
    .rst  (RESET),
    .din  (pin_eff),
    .tap  (dir_lat),
    .dout (nom_dly)
  );

  // dll-off timing is not modelled: nominal then tracks the pin undelayed
  assign nom_req = sync_mode ? nom_dly : pin_eff;

  trm_window u_rd_win (
    .clk    (MCLK),
    .rst    (RESET),
    .start  (READ_CMD),
    .off_in (rd_off),
    .len_in (rd_len),
    .active (rd_act)
  );

  trm_window u_wr_win (
    .clk    (MCLK),
    .rst    (RESET),
    .start  (WRITE_CMD && rtt_wr != 2'h0),
    .off_in (dir_lat),
    .len_in (wr_len),
    .active (wr_act)
  );

  always_comb begin
    next_state = TS_HIZ;
    next_code  = 3'h0;
    if (SELF_REFRESH) begin
      next_state = TS_HIZ;
    end else if (rd_act) begin
      next_state = TS_HIZ;
    end else if (wr_act) begin
      next_state = TS_WR;
      next_code  = {1'b0, rtt_wr};
    end else if (nom_req && rtt_nom != 3'h0) begin
      next_state = TS_NOM;
      next_code  = rtt_nom;
    end else if (rtt_park != 3'h0) begin
      next_state = TS_PARK;
      next_code  = rtt_park;
    end
    // code n means 240/n ohms, 0 means high impedance
    next_tdqs = (X8_DEVICE && ctrl[TDQS_BIT]) ? next_code : 3'h0;
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      DQ_TERM_STATE  <= TS_HIZ;
      DQ_TERM_CODE   <= 3'h0;
      TDQS_TERM_CODE <= 3'h0;
    end else begin
      DQ_TERM_STATE  <= next_state;
      DQ_TERM_CODE   <= next_code;
      TDQS_TERM_CODE <= next_tdqs;
    end
  end

  // a change counts only once the last two stages agree
  always_comb begin
    next_filt     = (s2 == s3) ? s3 : filt;
    next_pin_prev = pin_eff;
    hold_min      = ctrl[HCHOP_BIT] ? (pre2 ? HOLD_CHOP_2 : HOLD_CHOP_1)
                                    : (pre2 ? HOLD_FULL_2 : HOLD_FULL_1);
    hold_viol     = pin_prev && !pin_eff && (hold_cnt < hold_min);
    next_hold_cnt = hold_cnt;
    if (pin_eff && (!pin_prev || WRITE_CMD)) next_hold_cnt = 3'h1;
    else if (pin_eff && hold_cnt != 3'h7) next_hold_cnt = hold_cnt + 3'h1;
    // a violation in the cycle of a clear still sticks
    next_hold_err = hold_viol || (hold_err && !hold_clr);
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      s1       <= 1'b0;
      s2       <= 1'b0;
      s3       <= 1'b0;
      filt     <= 1'b0;
      pin_prev <= 1'b0;
      hold_cnt <= 3'h0;
      hold_err <= 1'b0;
    end else begin
      s1       <= TERM_EN_PIN;
      s2       <= s1;
      s3       <= s2;
      filt     <= next_filt;
      pin_prev <= next_pin_prev;
      hold_cnt <= next_hold_cnt;
      hold_err <= next_hold_err;
    end
  end

  always_comb begin
    stat = 32'h0;
    stat[ST_STATE +: 2] = DQ_TERM_STATE;
    stat[ST_CODE +: 3]  = DQ_TERM_CODE;
    stat[ST_PIN]        = pin_eff;
    stat[ST_SYNC]       = sync_mode;
    stat[ST_RD]         = rd_act;
    stat[ST_WR]         = wr_act;
  end

  // address and data may come in either order; response waits for both
  always_comb begin
    wa           = aw_held ? aw_addr : AWADDR;
    wd           = w_held ? w_data : WDATA;
    ws           = w_held ? w_strb : WSTRB;
    do_wr        = (aw_held || AWVALID) && (w_held || WVALID) && !BVALID;
    next_ctrl    = ctrl;
    next_lat     = lat;
    hold_clr     = 1'b0;
    next_aw_held = aw_held || (AWVALID && AWREADY);
    next_w_held  = w_held || (WVALID && WREADY);
    next_aw_addr = (AWVALID && AWREADY) ? AWADDR : aw_addr;
    next_w_data  = (WVALID && WREADY) ? WDATA : w_data;
    next_w_strb  = (WVALID && WREADY) ? WSTRB : w_strb;
    next_bvalid  = BVALID && !BREADY;
    next_bresp   = BRESP;
    if (do_wr) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      unique case ({wa[ADDR_W-1:2], 2'b00})
        CTRL_OFS: next_ctrl = 12'(merge(32'(ctrl), wd, ws));
        LAT_OFS:  next_lat  = 20'(merge(32'(lat), wd, ws));
        STAT_OFS: next_bresp = RESP_OKAY;
        HOLD_OFS: hold_clr  = ws[0] && wd[0];
        default:  next_bresp = RESP_SLVERR;
      endcase
    end
    next_rvalid = RVALID && !RREADY;
    next_rdata  = RDATA;
    next_rresp  = RRESP;
    if (ARVALID && ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case ({ARADDR[ADDR_W-1:2], 2'b00})
        CTRL_OFS: next_rdata = 32'(ctrl);
        LAT_OFS:  next_rdata = 32'(lat);
        STAT_OFS: next_rdata = stat;
        HOLD_OFS: next_rdata = 32'(hold_err);
        default: begin
          next_rdata = 32'h0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ctrl    <= CTRL_RST;
      lat     <= LAT_RST;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      BVALID  <= 1'b0;
      BRESP   <= RESP_OKAY;
      RVALID  <= 1'b0;
      RDATA   <= 32'h0;
      RRESP   <= RESP_OKAY;
    end else begin
      ctrl    <= next_ctrl;
      lat     <= next_lat;
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      BVALID  <= next_bvalid;
      BRESP   <= next_bresp;
      RVALID  <= next_rvalid;
      RDATA   <= next_rdata;
      RRESP   <= next_rresp;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);

  sequence s_three_high;
    $rose(pin_eff) ##1 pin_eff [*2] ##1 !pin_eff;
  endsequence

  AST_SREF_HIZ: assert property (SELF_REFRESH |=> DQ_TERM_STATE == TS_HIZ
                                 && DQ_TERM_CODE == 3'h0)
    else $error("termination active in self-refresh");
  AST_RD_HIZ: assert property (rd_act |=> DQ_TERM_STATE == TS_HIZ)
    else $error("termination active during read window");
  AST_WR_OVER_NOM: assert property (!SELF_REFRESH && !rd_act && wr_act
                                    |=> DQ_TERM_STATE == TS_WR
                                    && DQ_TERM_CODE == {1'b0, $past(rtt_wr)})
    else $error("write termination not chosen");
  AST_NOM_ON: assert property (!SELF_REFRESH && !rd_act && !wr_act && nom_req
                               && rtt_nom != 3'h0 |=> DQ_TERM_STATE == TS_NOM
                               && DQ_TERM_CODE == $past(rtt_nom))
    else $error("nominal termination not applied");
  AST_PARK: assert property (!SELF_REFRESH && !rd_act && !wr_act && !nom_req
                             && rtt_park != 3'h0 |=> DQ_TERM_STATE == TS_PARK)
    else $error("parked termination not applied");
  AST_RX_OFF: assert property (rtt_nom == 3'h0 ##1 rtt_nom == 3'h0
                               |=> DQ_TERM_STATE != TS_NOM)
    else $error("nominal applied while disabled");
  AST_TDQS: assert property (!X8_DEVICE |=> TDQS_TERM_CODE == 3'h0)
    else $error("termination strobe terminated on non-x8 part");
  AST_HOLD_FLAG: assert property (s_three_high |=> hold_err)
    else $error("short enable pulse not flagged");
  AST_RD_PRIO: assert property (rd_act && wr_act && !SELF_REFRESH
                                |=> DQ_TERM_STATE == TS_HIZ)
    else $error("read disable lost priority");
endmodule

// File: common/trm_pkg.sv
// termination control package: register map, field layout, latency constants
// assumes a 32-bit AXI4-Lite register bus and a single command clock
package trm_pkg;
  localparam int          ADDR_W      = 8;
  localparam logic [7:0]  CTRL_OFS    = 8'h00;
  localparam logic [7:0]  LAT_OFS     = 8'h04;
  localparam logic [7:0]  STAT_OFS    = 8'h08;
  localparam logic [7:0]  HOLD_OFS    = 8'h0c;
  localparam logic [11:0] CTRL_RST    = 12'h000;
  localparam logic [19:0] LAT_RST     = 20'h00000;
  // control fields
  localparam int          NOM_LSB     = 0;
  localparam int          PARK_LSB    = 3;
  localparam int          WRT_LSB     = 6;
  localparam int          PRE2_BIT    = 8;
  localparam int          CRC_BIT     = 9;
  localparam int          TDQS_BIT    = 10;
  localparam int          HCHOP_BIT   = 11;
  // latency fields, each FLD_W wide
  localparam int          FLD_W       = 5;
  localparam int          CASW_LSB    = 0;
  localparam int          ADDL_LSB    = 5;
  localparam int          PARL_LSB    = 10;
  localparam int          CASR_LSB    = 15;
  // status fields
  localparam int          ST_STATE    = 0;
  localparam int          ST_CODE     = 2;
  localparam int          ST_PIN      = 5;
  localparam int          ST_SYNC     = 6;
  localparam int          ST_RD       = 7;
  localparam int          ST_WR       = 8;
  // latency arithmetic in clock cycles, then counter widths and bus response codes
  localparam logic [6:0]  PRE1_SUB    = 7'h02;
  localparam logic [6:0]  PRE2_SUB    = 7'h03;
  localparam logic [3:0]  HALF_CHOP   = 4'h2;
  localparam logic [3:0]  HALF_FULL   = 4'h4;
  localparam logic [2:0]  HOLD_CHOP_1 = 3'h4;
  localparam logic [2:0]  HOLD_CHOP_2 = 3'h5;
  localparam logic [2:0]  HOLD_FULL_1 = 3'h6;
  localparam logic [2:0]  HOLD_FULL_2 = 3'h7;
  localparam logic [6:0]  LAT_MAX     = 7'h3f;
  localparam int          TAP_W       = 6;
  localparam int          DLY_DEPTH   = 64;
  localparam int          CNT_W       = 7;
  localparam int          LEN_W       = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TS_HIZ  = 2'b00,
    TS_PARK = 2'b01,
    TS_NOM  = 2'b10,
    TS_WR   = 2'b11
  } trm_state_t;
endpackage

// File: design/trm_delay.sv
// programmable delay line for the sampled termination enable
// assumes tap is held steady while in use; dout lags din by exactly tap cycles
`timescale 1ns/1ps
module trm_delay (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    din,
  input  wire logic [trm_pkg::TAP_W-1:0] tap,
  output logic                         dout
);
  import trm_pkg::*;

  logic [DLY_DEPTH-1:0] sh;
  logic [DLY_DEPTH-1:0] next_sh;

  always_comb begin
    next_sh = {sh[DLY_DEPTH-2:0], din};
    // tap 0 passes straight through, so no extra cycle hides in the line
    dout    = (tap == '0) ? din : sh[tap - TAP_W'(1)];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sh <= '0;
    end else begin
      sh <= next_sh;
    end
  end
endmodule

// File: design/trm_window.sv
// one-shot window timer: active for len cycles starting off cycles after start
// assumes start is a one-cycle pulse; a new start restarts the window
`timescale 1ns/1ps
module trm_window (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      start,
  input  wire logic [trm_pkg::TAP_W-1:0] off_in,
  input  wire logic [trm_pkg::LEN_W-1:0] len_in,
  output logic                           active
);
  import trm_pkg::*;

  logic             run;
  logic [CNT_W-1:0] cnt;
  logic [TAP_W-1:0] off;
  logic [LEN_W-1:0] len;
  logic             next_run;
  logic [CNT_W-1:0] next_cnt;
  logic [TAP_W-1:0] next_off;
  logic [LEN_W-1:0] next_len;
  logic [CNT_W-1:0] win_end;

  always_comb begin
    win_end  = CNT_W'(off) + CNT_W'(len);
    active   = run && (cnt >= CNT_W'(off)) && (cnt < win_end);
    next_run = run;
    next_cnt = cnt;
    next_off = off;
    next_len = len;
    if (start) begin
      next_run = 1'b1;
      next_cnt = '0;
      next_off = off_in;
      next_len = len_in;
    end else if (run) begin
      if (cnt + 7'h01 >= win_end) next_run = 1'b0;
      else next_cnt = cnt + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
      cnt <= '0;
      off <= '0;
      len <= '0;
    end else begin
      run <= next_run;
      cnt <= next_cnt;
      off <= next_off;
      len <= next_len;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_win_open;
    start && off_in == 6'h03 && len_in == 4'h4;
  endsequence

  sequence s_win_shape;
    !active [*3] ##1 active [*4] ##1 !active;
  endsequence

  AST_WIN_ZERO: assert property (start && off_in == 6'h00 && len_in != 4'h0 |=> active)
    else $error("window with zero offset did not open at once");
  AST_WIN_LEN: assert property (s_win_open |=> s_win_shape)
    else $error("window length or offset wrong");
endmodule

// File: dv/trm_host_model.sv
// host-side model: issues read and write commands, drives the enable pin
// assumes one-cycle requests from the bench on the command clock
`timescale 1ns/1ps
module trm_host_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       req,
  input  wire logic [1:0] kind,
  input  wire logic [4:0] len,
  input  wire logic       chop,
  input  wire logic       pre2,
  input  wire logic       short_ok,
  output logic            pin = 1'b0,
  output logic            rd_cmd = 1'b0,
  output logic            wr_cmd = 1'b0,
  output logic            chop_out = 1'b0
);
  // kind: 0 enable pulse of len cycles, stretched to hold_min unless short_ok, 1 read, 2 write
  logic       busy = 1'b0;
  logic [4:0] cnt = 5'h0;
  logic [4:0] hold_len = 5'h0;
  logic [4:0] hold_min;
  assign hold_min = chop ? (pre2 ? 5'h5 : 5'h4) : (pre2 ? 5'h7 : 5'h6);
  always @(posedge clk) begin
    rd_cmd <= req && kind == 2'h1;
    wr_cmd <= req && kind == 2'h2;
    if (req) begin
      chop_out <= chop;
    end
    if (rst) begin
      pin  <= 1'b0;
      busy <= 1'b0;
    end else if (req && kind == 2'h0 && !busy) begin
      pin      <= 1'b1;
      busy     <= 1'b1;
      cnt      <= 5'h1;
      hold_len <= len;
    end else if (req && kind == 2'h2 && busy) begin
      cnt <= 5'h1;
    end else if (busy) begin
      cnt <= cnt + 5'h1;
      // a short pulse only when a scenario asks for one
      if (cnt >= hold_len && (cnt >= hold_min || short_ok)) begin
        pin  <= 1'b0;
        busy <= 1'b0;
      end
    end
  end
endmodule

// File: dv/dram_termination_control_bench.sv
// self-checking bench for the termination control block
// assumes the host model drives the command strobes and the enable pin
`timescale 1ns/1ps
module dram_termination_control_bench;
  import trm_pkg::*;
  typedef struct packed {
    logic [11:0] ctrl;
    logic        pin;
    logic        x8;
    trm_state_t  st;
    logic [2:0]  code;
    logic [2:0]  tdqs;
    logic        rx;
  } trm_row_t;
  localparam trm_row_t ROWS [13] = '{
    '{12'h013, 1'b1, 1'b0, TS_NOM, 3'h3, 3'h0, 1'b1},
    '{12'h013, 1'b0, 1'b0, TS_PARK, 3'h2, 3'h0, 1'b1},
    '{12'h010, 1'b1, 1'b0, TS_PARK, 3'h2, 3'h0, 1'b0},
    '{12'h003, 1'b0, 1'b0, TS_HIZ, 3'h0, 3'h0, 1'b1},
    '{12'h000, 1'b1, 1'b0, TS_HIZ, 3'h0, 3'h0, 1'b0},
    '{12'h413, 1'b1, 1'b1, TS_NOM, 3'h3, 3'h3, 1'b1},
    '{12'h013, 1'b1, 1'b1, TS_NOM, 3'h3, 3'h0, 1'b1},
    '{12'h001, 1'b1, 1'b0, TS_NOM, 3'h1, 3'h0, 1'b1},
    '{12'h002, 1'b1, 1'b0, TS_NOM, 3'h2, 3'h0, 1'b1},
    '{12'h004, 1'b1, 1'b0, TS_NOM, 3'h4, 3'h0, 1'b1},
    '{12'h005, 1'b1, 1'b0, TS_NOM, 3'h5, 3'h0, 1'b1},
    '{12'h006, 1'b1, 1'b0, TS_NOM, 3'h6, 3'h0, 1'b1},
    '{12'h007, 1'b1, 1'b0, TS_NOM, 3'h7, 3'h0, 1'b1}
  };
  logic MCLK = 0, RESET = 1, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0, SELF_REFRESH = 0, DLL_LOCKED = 0, X8_DEVICE = 0;
  logic [7:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA;
  logic [3:0] WSTRB = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, TERM_RX_ON;
  logic [1:0] BRESP, RRESP;
  logic [2:0] DQ_TERM_CODE, TDQS_TERM_CODE;
  trm_state_t DQ_TERM_STATE;
  logic pin, rd, wr, chop, req = 0, chop_rq = 0, pre2 = 0, short_ok = 0;
  logic [1:0] kind = 0;
  logic [4:0] len = 0;
  int err_count = 0, num_checks = 0, cyc = 0;

  always #50 MCLK = ~MCLK;

  trm_ctrl i_trm_ctrl (.MCLK(MCLK), .RESET(RESET), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
    .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TERM_EN_PIN(pin), .READ_CMD(rd), .WRITE_CMD(wr), .BURST_CHOP(chop),
    .SELF_REFRESH(SELF_REFRESH), .DLL_LOCKED(DLL_LOCKED), .X8_DEVICE(X8_DEVICE),
    .DQ_TERM_STATE(DQ_TERM_STATE), .DQ_TERM_CODE(DQ_TERM_CODE),
    .TDQS_TERM_CODE(TDQS_TERM_CODE), .TERM_RX_ON(TERM_RX_ON));
  trm_host_model i_trm_host_model (.clk(MCLK), .rst(RESET), .req(req), .kind(kind),
    .len(len), .chop(chop_rq), .pre2(pre2), .short_ok(short_ok), .pin(pin),
    .rd_cmd(rd), .wr_cmd(wr), .chop_out(chop));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hf;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    while (!(aw && w)) begin
      @(negedge MCLK);
      aw = aw | (AWVALID & AWREADY);
      w = w | (WVALID & WREADY);
      @(posedge MCLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
    end
    // released payload must not look valid
    AWADDR <= ~a;
    WDATA <= ~d;
    BREADY <= 1'b1;
    while (!b) begin
      @(negedge MCLK);
      b = BVALID;
      r = BRESP;
      @(posedge MCLK);
    end
    BREADY <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, g;
    ar = 0;
    g = 0;
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!g) begin
      @(negedge MCLK);
      ar = ar | (ARVALID & ARREADY);
      g = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge MCLK);
      if (ar) ARVALID <= 1'b0;
      if (ar) ARADDR <= ~a;
    end
    RREADY <= 1'b0;
  endtask

  task automatic host(input logic [1:0] k, input logic [4:0] n);
    kind <= k;
    len <= n;
    req <= 1'b1;
    @(posedge MCLK);
    req <= 1'b0;
  endtask

  // i counts edges from the one that samples the command
  task automatic win(input logic [1:0] k, input int off, input int n,
                     input trm_state_t s, input trm_state_t b);
    host(k, 5'h1);
    for (int i = 0; i <= off + n + 1; i++) begin
      @(posedge MCLK);
      @(negedge MCLK);
      chk("win_state", 32'((i > off && i <= off + n) ? s : b), 32'(DQ_TERM_STATE));
    end
    @(posedge MCLK);
  endtask

  // only the difference between modes is judged: the filter delay cancels
  task automatic meas(input logic dll, output int t_on, output int t_off);
    DLL_LOCKED <= dll;
    repeat (4) @(posedge MCLK);
    host(2'h0, 5'd14);
    t_on = 0;
    t_off = 0;
    do begin
      @(negedge MCLK);
      t_on++;
    end while (DQ_TERM_STATE !== TS_NOM && t_on < 40);
    while (pin) @(negedge MCLK);
    do begin
      @(negedge MCLK);
      t_off++;
    end while (DQ_TERM_STATE === TS_NOM && t_off < 40);
    repeat (20) @(posedge MCLK);
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int a0, f0, a1, f1;
    repeat (6) @(posedge MCLK);
    RESET <= 1'b0;
    @(negedge MCLK);
    chk("rst_state", 32'h0, 32'(DQ_TERM_STATE));
    chk("rst_rx", 32'h0, 32'(TERM_RX_ON));
    @(posedge MCLK);
    axi_rd(CTRL_OFS, d, r);
    chk("ctrl_rst", 32'h0, d);
    axi_rd(LAT_OFS, d, r);
    chk("lat_rst", 32'h0, d);
    axi_rd(8'h10, d, r);
    chk("unmapped_rresp", 32'(RESP_SLVERR), 32'(r));
    axi_wr(8'h10, 32'h1, r);
    chk("unmapped_bresp", 32'(RESP_SLVERR), 32'(r));
    $display("test registers done");
    foreach (ROWS[i]) begin
      X8_DEVICE <= ROWS[i].x8;
      axi_wr(CTRL_OFS, 32'(ROWS[i].ctrl), r);
      if (ROWS[i].pin) host(2'h0, 5'd20);
      repeat (10) @(posedge MCLK);
      @(negedge MCLK);
      chk("tbl_state", 32'(ROWS[i].st), 32'(DQ_TERM_STATE));
      chk("tbl_code", 32'(ROWS[i].code), 32'(DQ_TERM_CODE));
      chk("tbl_tdqs", 32'(ROWS[i].tdqs), 32'(TDQS_TERM_CODE));
      chk("tbl_rx", 32'(ROWS[i].rx), 32'(TERM_RX_ON));
      @(posedge MCLK);
      axi_rd(STAT_OFS, d, r);
      chk("tbl_stat", 32'({ROWS[i].code, ROWS[i].st}), 32'(d[4:0]));
      repeat (14) @(posedge MCLK);
    end
    axi_rd(CTRL_OFS, d, r);
    chk("ctrl_back", 32'h007, d);
    $display("test state table done");
    axi_wr(CTRL_OFS, 32'h010, r);
    win(2'h1, 0, 6, TS_HIZ, TS_PARK);
    axi_wr(LAT_OFS, 32'h28000, r);
    for (int m = 0; m < 8; m++) begin
      chop_rq <= m[0];
      pre2 <= m[1];
      axi_wr(CTRL_OFS, {22'h0, m[2], m[1], 8'h10}, r);
      win(2'h1, 3 - m[1], (m[0] ? 2 : 4) + (m[1] ? 3 : 2) + m[2], TS_HIZ, TS_PARK);
    end
    $display("test read windows done");
    axi_wr(LAT_OFS, 32'h444, r);
    for (int w = 0; w < 2; w++) begin
      chop_rq <= w[0];
      pre2 <= w[0];
      axi_wr(CTRL_OFS, {23'h0, w[0], 8'h53}, r);
      host(2'h0, 5'd24);
      repeat (8) @(posedge MCLK);
      win(2'h2, 5 - w, w ? 5 : 6, TS_WR, TS_NOM);
      repeat (16) @(posedge MCLK);
    end
    $display("test write windows done");
    chop_rq <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      pre2 <= p[0];
      axi_wr(CTRL_OFS, {23'h0, p[0], 8'h13}, r);
      meas(1'b0, a0, f0);
      meas(1'b1, a1, f1);
      chk("on_lat", 32'(5 - p), 32'(a1 - a0));
      chk("off_lat", 32'(5 - p), 32'(f1 - f0));
    end
    DLL_LOCKED <= 1'b0;
    $display("test sync latency done");
    host(2'h0, 5'd20);
    repeat (10) @(posedge MCLK);
    SELF_REFRESH <= 1'b1;
    @(posedge MCLK);
    @(negedge MCLK);
    chk("sr_state", 32'(TS_HIZ), 32'(DQ_TERM_STATE));
    chk("sr_rx", 32'h0, 32'(TERM_RX_ON));
    @(posedge MCLK);
    SELF_REFRESH <= 1'b0;
    pre2 <= 1'b0;
    repeat (20) @(posedge MCLK);
    $display("test self refresh done");
    axi_wr(CTRL_OFS, 32'h013, r);
    // self-refresh cut the last enable pulse short and left the flag set
    axi_wr(HOLD_OFS, 32'h1, r);
    host(2'h0, 5'd6);
    repeat (16) @(posedge MCLK);
    axi_rd(HOLD_OFS, d, r);
    chk("hold_ok", 32'h0, 32'(d[0]));
    short_ok <= 1'b1;
    host(2'h0, 5'd3);
    repeat (16) @(posedge MCLK);
    short_ok <= 1'b0;
    axi_rd(HOLD_OFS, d, r);
    chk("hold_short", 32'h1, 32'(d[0]));
    axi_wr(HOLD_OFS, 32'h1, r);
    axi_rd(HOLD_OFS, d, r);
    chk("hold_clear", 32'h0, 32'(d[0]));
    $display("test hold check done");
    print_verdict();
  end
endmodule
